/* File: common/iox_pkg.sv */
// shared constants and types of the sixteen-bit i2c target port expander
package iox_pkg;
  // port and bus geometry
  localparam int PORT_W = 16;
  localparam logic [6:0] TGT_ADDR_BASE = 7'h20;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] FIRST_BIT_CNT = 4'h1;

  // command pointer: bits 2:1 pick the register pair, bit 0 the byte
  localparam logic [2:0] CMD_IN0 = 3'h0;
  localparam logic [2:0] CMD_IN1 = 3'h1;
  localparam logic [1:0] GRP_IN = 2'h0;
  localparam logic [1:0] GRP_OUT = 2'h1;
  localparam logic [1:0] GRP_POL = 2'h2;
  localparam logic [1:0] GRP_CFG = 2'h3;

  // register reset values
  localparam logic [15:0] OUT_RST = 16'hffff;
  localparam logic [15:0] POL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'hffff;
  localparam logic [15:0] PINS_RELEASED = 16'hffff;

  // cycles after reset release before the pin synchroniser holds real levels
  localparam logic [1:0] INIT_DONE = 2'h3;

  // timing
  localparam int SYS_CLK_MHZ = 40;
  localparam int ALERT_VALID_DELAY_NS = 4000;
  localparam int ALERT_VALID_CYC = ALERT_VALID_DELAY_NS * SYS_CLK_MHZ / 1000;

  // events handed from the bus side to the register side
  typedef enum logic [2:0] {
    EV_START  = 3'b000,
    EV_STOP   = 3'b001,
    EV_ADDR_W = 3'b010,
    EV_ADDR_R = 3'b011,
    EV_WRBYTE = 3'b100,
    EV_RDACK  = 3'b101
  } iox_evt_kind_t;

  typedef struct packed {
    iox_evt_kind_t kind;
    logic [7:0] data;
    logic nack;
  } iox_evt_t;

  // open-drain pin drive: o is the level, oe_n low while pulling
  typedef struct packed {
    logic o;
    logic oe_n;
  } iox_od_t;

  typedef enum logic [2:0] {
    LS_IDLE  = 3'b000,
    LS_ADDR  = 3'b001,
    LS_ACK_A = 3'b010,
    LS_WR    = 3'b011,
    LS_ACK_W = 3'b100,
    LS_RD    = 3'b101,
    LS_ACK_R = 3'b110
  } iox_lstate_t;

  // state of the bus-facing domain
  typedef struct packed {
    logic scl_m;
    logic scl_y;
    logic sda_m;
    logic sda_y;
    logic sel_m;
    logic sel_y;
    logic por_m;
    logic por_y;
    logic rsp_m;
    logic rsp_y;
    logic rsp_seen;
    logic [1:0] scl_h;
    logic [1:0] sda_h;
    logic scl_f;
    logic sda_f;
    iox_lstate_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic nack;
    logic [7:0] txb;
    iox_od_t sda;
    logic evt_tgl;
    iox_evt_t evt;
  } iox_link_st_t;

  // state of the register and port domain
  typedef struct packed {
    logic evt_m;
    logic evt_y;
    logic evt_seen;
    logic por_m;
    logic por_y;
    logic [15:0] pin_m;
    logic [15:0] pin_y;
    logic [1:0] init;
    logic [15:0] out;
    logic [15:0] pol;
    logic [15:0] cfg;
    logic [15:0] snap;
    logic [2:0] cmd;
    logic first;
    logic rsp_tgl;
    logic [7:0] tx;
    logic [15:0] pin_o;
    logic [15:0] pin_oe_n;
    iox_od_t alert;
  } iox_sys_st_t;

  localparam iox_link_st_t LINK_RST = '{
    st: LS_IDLE,
    evt: '{kind: EV_START, data: 8'h00, nack: 1'b0},
    sda: '{o: 1'b0, oe_n: 1'b1},
    default: '0
  };

  localparam iox_sys_st_t SYS_RST = '{
    out: OUT_RST,
    pol: POL_RST,
    cfg: CFG_RST,
    pin_o: OUT_RST,
    pin_oe_n: PINS_RELEASED,
    alert: '{o: 1'b0, oe_n: 1'b1},
    default: '0
  };
endpackage

/* File: rtl/iox_core.sv */
// i2c target port expander: bus engine on the sample clock, registers and pins on sys_clk
`timescale 1ns/1ps

// Behaviour
// RL1: input-mode pins have both drivers off, pin floats.
// RL2: output-mode pins drive the output register bit high or low.
// RL3: any edge on an input-mode pin raises the alert within the valid delay.
// RL4: alert clears when the pin returns, or when its input port is read.
// RL5: read clear happens at the acknowledge bit after its SCL rise.
// RL6: pin changes during that acknowledge pulse may be lost or brief.
// RL7: after clearing, every further input change alerts again.
// RL8: other targets' traffic and output-mode pins never touch the alert.
// RL9: switching a pin to input with a differing level may alert.
// RL10: alert is active low open drain, only ever pulls low.
// RL11: reset pin low forces registers and bus engine to defaults.
// RL12: the outside holds reset low at least the minimum pulse width.
// RL13: held in reset until port supply is good, then defaults.
// RL14: start is SDA falling while SCL high.
// RL15: controller sends address MSB first, direction bit last.
// RL16: address bits 0100 00, select pin, r/w; pin n is data bit n.
// RL17: matching address is acknowledged by holding SDA low through ACK high.
// RL18: address select must not change between start and stop.
// RL19: one bit per SCL pulse, SDA stable while SCL high.
// RL20: stop is SDA rising while SCL high.
// RL21: every byte gets one ACK bit from the receiver, transmitter releases.
// RL22: controller NACK ends a read, device releases SDA.
// RL23: alert active while an input pin differs from the input snapshot.
// RL24: target address 0x20 with select low, 0x21 with select high.
// RL25: SCL and SDA are synchronised and deglitched before edge decisions.
module iox_core (
  // clocks and reset
  input wire logic sys_clk,
  input wire logic bus_smp_clk,
  input wire logic arst_n,
  // power and strap
  input wire logic port_supply_ok,
  input wire logic addr_sel,
  // i2c link
  input wire logic scl,
  input wire logic sda_line,
  output iox_pkg::iox_od_t sda_drv,
  // port pins
  input wire logic [iox_pkg::PORT_W-1:0] port_pins,
  output logic [iox_pkg::PORT_W-1:0] port_out,
  output logic [iox_pkg::PORT_W-1:0] port_oe_n,
  // change alert
  output iox_pkg::iox_od_t alert_drv
);
  import iox_pkg::*;

  localparam int AV_MAX = ALERT_VALID_CYC;

  iox_link_st_t lq;
  iox_link_st_t ld;
  iox_sys_st_t sq;
  iox_sys_st_t sd;
  logic scl_nf;
  logic sda_nf;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;
  logic addr_hit;
  logic ev_new;

  function automatic logic [7:0] byte_of(input logic [15:0] w, input logic hi);
    byte_of = hi ? w[15:8] : w[7:0];
  endfunction

  function automatic logic [15:0] put_byte(input logic [15:0] w, input logic hi,
                                           input logic [7:0] b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction

  // byte returned for a read at the current pointer; inputs honour inversion
  function automatic logic [7:0] rd_byte(input logic [2:0] cmd, input logic [15:0] pins,
                                         input logic [15:0] out, input logic [15:0] pol,
                                         input logic [15:0] cfg);
    case (cmd[2:1])
      GRP_IN: rd_byte = byte_of(pins ^ pol, cmd[0]); // RL16
      GRP_OUT: rd_byte = byte_of(out, cmd[0]);
      GRP_POL: rd_byte = byte_of(pol, cmd[0]);
      default: rd_byte = byte_of(cfg, cmd[0]);
    endcase
  endfunction

  // filtered line levels: a level is taken only after three equal samples
  assign scl_nf = (lq.scl_y == lq.scl_h[0] && lq.scl_h[0] == lq.scl_h[1]) ?
                  lq.scl_y : lq.scl_f; // RL25
  assign sda_nf = (lq.sda_y == lq.sda_h[0] && lq.sda_h[0] == lq.sda_h[1]) ?
                  lq.sda_y : lq.sda_f; // RL25
  assign start_c = lq.scl_f && scl_nf && lq.sda_f && !sda_nf; // RL14
  assign stop_c = lq.scl_f && scl_nf && !lq.sda_f && sda_nf; // RL20
  assign rise_c = !lq.scl_f && scl_nf;
  assign fall_c = lq.scl_f && !scl_nf;
  assign addr_hit = (lq.sh[7:1] == {TGT_ADDR_BASE[6:1], lq.sel_y}); // RL24

  // bus engine next state
  always_comb begin
    ld = lq;
    ld.scl_m = scl;
    ld.scl_y = lq.scl_m;
    ld.sda_m = sda_line;
    ld.sda_y = lq.sda_m;
    ld.sel_m = addr_sel;
    ld.sel_y = lq.sel_m;
    ld.por_m = port_supply_ok;
    ld.por_y = lq.por_m;
    ld.rsp_m = sq.rsp_tgl;
    ld.rsp_y = lq.rsp_m;
    ld.scl_h = {lq.scl_h[0], lq.scl_y};
    ld.sda_h = {lq.sda_h[0], lq.sda_y};
    ld.scl_f = scl_nf;
    ld.sda_f = sda_nf;
    // tx byte is stable on the register side once its toggle has crossed
    if (lq.rsp_y != lq.rsp_seen) begin
      ld.rsp_seen = lq.rsp_y;
      ld.txb = sq.tx;
    end
    if (!lq.por_y) begin
      ld.st = LS_IDLE; // RL13
      ld.cnt = '0;
      ld.sda.oe_n = 1'b1;
    end else if (start_c) begin
      ld.st = LS_ADDR; // RL14
      ld.cnt = '0;
      ld.sda.oe_n = 1'b1;
      ld.evt = '{kind: EV_START, data: 8'h00, nack: 1'b0};
      ld.evt_tgl = ~lq.evt_tgl;
    end else if (stop_c) begin
      ld.st = LS_IDLE; // RL20
      ld.sda.oe_n = 1'b1;
      ld.evt = '{kind: EV_STOP, data: 8'h00, nack: 1'b0};
      ld.evt_tgl = ~lq.evt_tgl;
    end else begin
      case (lq.st)
        LS_ADDR, LS_WR: begin
          if (rise_c) begin
            ld.sh = {lq.sh[6:0], sda_nf}; // RL19
            ld.cnt = lq.cnt + FIRST_BIT_CNT;
          end else if (fall_c && lq.cnt == BITS_PER_BYTE) begin
            if (lq.st == LS_WR) begin
              ld.st = LS_ACK_W;
              ld.sda.oe_n = 1'b0; // RL21
              ld.evt = '{kind: EV_WRBYTE, data: lq.sh, nack: 1'b0};
              ld.evt_tgl = ~lq.evt_tgl;
            end else if (addr_hit) begin
              ld.st = LS_ACK_A;
              ld.rw = lq.sh[0];
              ld.sda.oe_n = 1'b0; // RL17
              ld.evt = '{kind: lq.sh[0] ? EV_ADDR_R : EV_ADDR_W, data: lq.sh, nack: 1'b0};
              ld.evt_tgl = ~lq.evt_tgl;
            end else begin
              ld.st = LS_IDLE; // RL8
            end
          end
        end
        LS_ACK_A, LS_ACK_W: begin
          if (fall_c) begin
            ld.cnt = '0;
            ld.sda.oe_n = 1'b1; // RL21
            ld.st = LS_WR;
            if (lq.st == LS_ACK_A && lq.rw) begin
              ld.st = LS_RD;
              ld.sh = lq.txb;
              ld.sda.oe_n = lq.txb[7];
              ld.cnt = FIRST_BIT_CNT;
            end
          end
        end
        LS_RD: begin
          if (fall_c) begin
            if (lq.cnt == BITS_PER_BYTE) begin
              ld.st = LS_ACK_R;
              ld.sda.oe_n = 1'b1; // RL21
            end else begin
              ld.sh = {lq.sh[6:0], 1'b0};
              ld.sda.oe_n = lq.sh[6];
              ld.cnt = lq.cnt + FIRST_BIT_CNT;
            end
          end
        end
        LS_ACK_R: begin
          if (rise_c) begin
            // clearing at this edge is why a pin change here may be missed
            ld.nack = sda_nf; // RL5 RL6
            ld.evt = '{kind: EV_RDACK, data: lq.txb, nack: sda_nf};
            ld.evt_tgl = ~lq.evt_tgl;
          end else if (fall_c) begin
            if (lq.nack) begin
              ld.st = LS_IDLE; // RL22
            end else begin
              ld.st = LS_RD;
              ld.sh = lq.txb;
              ld.sda.oe_n = lq.txb[7];
              ld.cnt = FIRST_BIT_CNT;
            end
          end
        end
        default: ld.st = LS_IDLE;
      endcase
    end
  end

  // bus engine registers; reset pin low holds the engine idle
  always_ff @(posedge bus_smp_clk or negedge arst_n) begin
    if (!arst_n) begin
      lq <= LINK_RST; // RL11
    end else begin
      lq <= ld;
    end
  end

  assign ev_new = (sq.evt_y != sq.evt_seen);

  // register side next state
  always_comb begin
    sd = sq;
    sd.evt_m = lq.evt_tgl;
    sd.evt_y = sq.evt_m;
    sd.por_m = port_supply_ok;
    sd.por_y = sq.por_m;
    sd.pin_m = port_pins;
    sd.pin_y = sq.pin_m;
    if (!sq.por_y) begin
      // supply below threshold acts like the reset pin
      sd.out = OUT_RST; // RL13
      sd.pol = POL_RST;
      sd.cfg = CFG_RST;
      sd.cmd = CMD_IN0;
      sd.first = 1'b0;
      sd.init = '0;
      sd.evt_seen = sq.evt_y;
    end else begin
      // snapshot the pins once the synchroniser holds them, so no alert at start
      if (sq.init != INIT_DONE) begin
        sd.init = sq.init + 2'h1;
        sd.snap = sq.pin_y;
      end
      // payload is stable in the bus domain while its toggle crosses
      if (ev_new) begin
        sd.evt_seen = sq.evt_y;
        case (lq.evt.kind)
          EV_ADDR_W: sd.first = 1'b1;
          EV_ADDR_R: begin
            sd.tx = rd_byte(sq.cmd, sq.pin_y, sq.out, sq.pol, sq.cfg);
            sd.rsp_tgl = ~sq.rsp_tgl;
          end
          EV_WRBYTE: begin
            if (sq.first) begin
              sd.cmd = lq.evt.data[2:0];
              sd.first = 1'b0;
            end else begin
              case (sq.cmd[2:1])
                GRP_OUT: sd.out = put_byte(sq.out, sq.cmd[0], lq.evt.data);
                GRP_POL: sd.pol = put_byte(sq.pol, sq.cmd[0], lq.evt.data);
                GRP_CFG: sd.cfg = put_byte(sq.cfg, sq.cmd[0], lq.evt.data);
                default: sd.cmd = sq.cmd; // input ports ignore writes
              endcase
              sd.cmd = {sq.cmd[2:1], ~sq.cmd[0]};
            end
          end
          EV_RDACK: begin
            if (sq.cmd[2:1] == GRP_IN) begin
              sd.snap = put_byte(sq.snap, sq.cmd[0], byte_of(sq.pin_y, sq.cmd[0])); // RL4
            end
            if (!lq.evt.nack) begin
              sd.cmd = {sq.cmd[2:1], ~sq.cmd[0]};
              sd.tx = rd_byte({sq.cmd[2:1], ~sq.cmd[0]}, sq.pin_y, sq.out, sq.pol, sq.cfg);
              sd.rsp_tgl = ~sq.rsp_tgl;
            end
          end
          default: sd.first = sq.first; // start and stop change nothing here
        endcase
      end
    end
    // pins follow the registers; a set cfg bit floats the pin
    sd.pin_oe_n = sd.cfg; // RL1
    sd.pin_o = sd.out; // RL2
    // compare only input-mode pins, so outputs never alert and a
    // direction change can alert against a stale snapshot
    sd.alert.o = 1'b0; // RL10
    sd.alert.oe_n = !(sq.por_y && sq.init == INIT_DONE &&
                      (|((sq.pin_y ^ sq.snap) & sq.cfg))); // RL3 RL7 RL8 RL9 RL23
  end

  // register side flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sq <= SYS_RST; // RL11
    end else begin
      sq <= sd;
    end
  end

  // outputs straight from flops
  assign sda_drv = lq.sda;
  assign port_out = sq.pin_o;
  assign port_oe_n = sq.pin_oe_n;
  assign alert_drv = sq.alert;

  // checks on the register side
  property p_hiz;
    @(posedge sys_clk) disable iff (!arst_n)
      sq.por_y |=> (port_oe_n == $past(sd.cfg));
  endproperty
  a_hiz: assert property (p_hiz) else $error("input pin not floating"); // RL1

  property p_drive;
    @(posedge sys_clk) disable iff (!arst_n)
      1'b1 |-> (((port_out ^ sq.out) & ~port_oe_n) == '0);
  endproperty
  a_drive: assert property (p_drive) else $error("output pin level wrong"); // RL2

  property p_alert_set;
    @(posedge sys_clk) disable iff (!arst_n)
      (sq.por_y && sq.init == INIT_DONE && (|((sq.pin_y ^ sq.snap) & sq.cfg)))
      |-> ##[1:AV_MAX] !alert_drv.oe_n;
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("alert late"); // RL3

  property p_rd_clear;
    @(posedge sys_clk) disable iff (!arst_n)
      (sq.por_y && ev_new && lq.evt.kind == EV_RDACK && sq.cmd == CMD_IN1)
      |=> (sq.snap[15:8] == $past(sq.pin_y[15:8]));
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("read did not clear"); // RL4

  property p_out_quiet;
    @(posedge sys_clk) disable iff (!arst_n)
      (sq.cfg == '0) |=> alert_drv.oe_n;
  endproperty
  a_out_quiet: assert property (p_out_quiet) else $error("output pin alerted"); // RL8

  property p_od_alert;
    @(posedge sys_clk) disable iff (!arst_n)
      !alert_drv.o;
  endproperty
  a_od_alert: assert property (p_od_alert) else $error("alert drives high"); // RL10

  property p_por_dflt;
    @(posedge sys_clk) disable iff (!arst_n)
      !sq.por_y |=> (sq.cfg == CFG_RST && sq.out == OUT_RST && sq.pol == POL_RST);
  endproperty
  a_por_dflt: assert property (p_por_dflt) else $error("defaults not restored"); // RL13

  // checks on the bus engine
  sequence s_addr_done;
    lq.por_y && !start_c && !stop_c && lq.st == LS_ADDR && fall_c &&
    lq.cnt == BITS_PER_BYTE;
  endsequence

  sequence s_wr_done;
    lq.por_y && !start_c && !stop_c && lq.st == LS_WR && fall_c &&
    lq.cnt == BITS_PER_BYTE;
  endsequence

  property p_start;
    @(posedge bus_smp_clk) disable iff (!arst_n)
      (lq.por_y && start_c) |=> (lq.st == LS_ADDR && lq.cnt == '0 && lq.sda.oe_n);
  endproperty
  a_start: assert property (p_start) else $error("start not taken"); // RL14

  property p_stop;
    @(posedge bus_smp_clk) disable iff (!arst_n)
      (lq.por_y && stop_c) |=> (lq.st == LS_IDLE && lq.sda.oe_n);
  endproperty
  a_stop: assert property (p_stop) else $error("stop not taken"); // RL20

  property p_addr_ack;
    @(posedge bus_smp_clk) disable iff (!arst_n)
      (s_addr_done ##0 addr_hit) |=> (lq.st == LS_ACK_A && !lq.sda.oe_n);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked"); // RL17

  property p_addr_miss;
    @(posedge bus_smp_clk) disable iff (!arst_n)
      (s_addr_done ##0 !addr_hit) |=> (lq.st == LS_IDLE && lq.sda.oe_n);
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked"); // RL24

  property p_wr_ack;
    @(posedge bus_smp_clk) disable iff (!arst_n)
      s_wr_done |=> (lq.st == LS_ACK_W && !lq.sda.oe_n && lq.evt.data == $past(lq.sh));
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("byte not acked"); // RL21

  property p_nack_rel;
    @(posedge bus_smp_clk) disable iff (!arst_n)
      (lq.st == LS_ACK_R) |-> lq.sda.oe_n;
  endproperty
  a_nack_rel: assert property (p_nack_rel) else $error("sda held in ack slot"); // RL22

  property p_hold;
    @(posedge bus_smp_clk) disable iff (!arst_n)
      (lq.por_y && lq.st == LS_RD && lq.scl_f && scl_nf && !start_c && !stop_c)
      |=> $stable(lq.sda.oe_n);
  endproperty
  a_hold: assert property (p_hold) else $error("sda moved while scl high"); // RL19
endmodule

/* File: verif/iox_i2c_ctrl.sv */
// i2c bus controller model that talks to the expander's link pins
`timescale 1ns/1ps
module iox_i2c_ctrl (
  // i2c lines, the controller only ever pulls sda low
  output logic scl,
  output logic sda_pull,
  input wire logic sda_line
);
  // a quarter of a 400 khz scl period
  localparam int QTR = 625;

  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // one bit: sda moves only while scl is low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    #QTR scl = 1'b1;
    #QTR r = sda_line;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  // also serves as a repeated start from scl low
  task automatic start_c();
    sda_pull = 1'b0;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b1;
    #QTR scl = 1'b0;
    #QTR;
  endtask

  task automatic stop_c();
    sda_pull = 1'b1;
    #QTR scl = 1'b1;
    #QTR sda_pull = 1'b0;
    #QTR;
  endtask

  // msb first, then the ninth bit left free for the target
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask

  // a nack leaves sda high so the target lets go before the stop
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!ack, r);
  endtask
endmodule

/* File: verif/iox_core_tb.sv */
// self-checking bench of the expander core against a register and alert model
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, s); end end
module iox_core_tb;
  import iox_pkg::*;
  logic sys_clk = 1'b0;
  logic bus_smp_clk = 1'b0;
  logic arst_n = 1'b0;
  logic supply_ok = 1'b0;
  logic addr_sel = 1'b0;
  logic [15:0] ext = 16'h0000;
  logic scl;
  logic sda_pull;
  iox_od_t sda_drv;
  iox_od_t alert_drv;
  logic [15:0] port_out;
  logic [15:0] port_oe_n;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] seed = 32'h000047ab;
  logic [15:0] m_out, m_pol, m_cfg, m_snap;
  // pulled-up wires: low only while someone pulls
  wire logic sda_line = !((sda_drv.oe_n === 1'b0) || sda_pull);
  wire logic alert_n = alert_drv.oe_n;
  // released pins follow the outside world, driven pins the output levels
  wire logic [15:0] port_pins = (~port_oe_n & port_out) | (port_oe_n & ext);

  always #12.5 sys_clk = ~sys_clk;
  always #16 bus_smp_clk = ~bus_smp_clk;

  iox_core i_dut (.sys_clk(sys_clk), .bus_smp_clk(bus_smp_clk), .arst_n(arst_n),
    .port_supply_ok(supply_ok), .addr_sel(addr_sel), .scl(scl), .sda_line(sda_line),
    .sda_drv(sda_drv), .port_pins(port_pins), .port_out(port_out),
    .port_oe_n(port_oe_n), .alert_drv(alert_drv));
  iox_i2c_ctrl i_ctl (.scl(scl), .sda_pull(sda_pull), .sda_line(sda_line));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] pins_m();
    return (~m_cfg & m_out) | (m_cfg & ext);
  endfunction

  // input group reads pins through polarity, others the stored value
  function automatic logic [7:0] reg_byte(input logic [2:0] p);
    logic [15:0] v;
    case (p[2:1])
      GRP_IN: v = pins_m() ^ m_pol;
      GRP_OUT: v = m_out;
      GRP_POL: v = m_pol;
      default: v = m_cfg;
    endcase
    return v[8*p[0] +: 8];
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic set_ext(input logic [15:0] v);
    @(posedge sys_clk);
    ext <= v;
    @(posedge sys_clk);
  endtask

  // wait for the alert to settle on the model's value, bounded by the valid delay
  task automatic chk_alert();
    int i;
    logic e;
    e = !(|((pins_m() ^ m_snap) & m_cfg));
    for (i = 0; i < ALERT_VALID_CYC && alert_n !== e; i++) @(posedge sys_clk);
    // judged on the line itself, so an alert still unsettled after the bound fails and ends the run
    if (alert_n !== e) begin
      n_fail++;
      close_out();
    end
    `CHK("alert", e, alert_n)
  endtask

  task automatic addr(input logic rw);
    logic ack;
    i_ctl.start_c();
    i_ctl.send({TGT_ADDR_BASE | {6'h00, addr_sel}, rw}, ack);
    `CHK("addr ack", 1'b1, ack)
  endtask

  task automatic wr(input logic [2:0] c, input logic [7:0] d0, input logic [7:0] d1);
    logic ack;
    logic [2:0] p;
    logic [7:0] d[2];
    d = '{d0, d1};
    p = c;
    addr(1'b0);
    i_ctl.send({5'h00, c}, ack);
    `CHK("cmd ack", 1'b1, ack)
    for (int k = 0; k < 2; k++) begin
      i_ctl.send(d[k], ack);
      `CHK("data ack", 1'b1, ack)
      if (p[2:1] == GRP_OUT) m_out[8*p[0] +: 8] = d[k];
      if (p[2:1] == GRP_POL) m_pol[8*p[0] +: 8] = d[k];
      if (p[2:1] == GRP_CFG) m_cfg[8*p[0] +: 8] = d[k];
      p[0] = ~p[0];
    end
    i_ctl.stop_c();
    cyc(10);
  endtask

  // two bytes: the first acked, the second nacked
  task automatic rd(input logic [2:0] c);
    logic ack;
    logic [7:0] d;
    logic [2:0] p;
    p = c;
    addr(1'b0);
    i_ctl.send({5'h00, c}, ack);
    `CHK("rd cmd ack", 1'b1, ack)
    addr(1'b1);
    for (int k = 0; k < 2; k++) begin
      i_ctl.recv(k == 0, d);
      `CHK("read byte", reg_byte(p), d)
      if (p[2:1] == GRP_IN) m_snap[8*p[0] +: 8] = pins_m()[8*p[0] +: 8];
      p[0] = ~p[0];
    end
    i_ctl.stop_c();
    cyc(10);
  endtask

  // the other strap address must be left alone
  task automatic foreign();
    logic ack;
    i_ctl.start_c();
    i_ctl.send({TGT_ADDR_BASE[6:1], ~addr_sel, 1'b0}, ack);
    `CHK("foreign ack", 1'b0, ack)
    i_ctl.stop_c();
  endtask

  task automatic pulse_reset(input logic via_supply);
    @(posedge sys_clk);
    if (via_supply) supply_ok <= 1'b0;
    else arst_n <= 1'b0;
    cyc(8);
    m_out = OUT_RST;
    m_pol = POL_RST;
    m_cfg = CFG_RST;
    `CHK("out in reset", OUT_RST, port_out)
    `CHK("oe in reset", CFG_RST, port_oe_n)
    supply_ok <= 1'b1;
    arst_n <= 1'b1;
    cyc(30);
    m_snap = ext;
  endtask

  initial begin
    pulse_reset(1'b0);
    chk_alert();
    for (int c = 2; c < 8; c += 2) rd(3'(c));
    $display("test reset_defaults done");
    wr(3'h3, 8'(rnd()), 8'(rnd()));
    wr(3'h5, 8'(rnd()), 8'(rnd()));
    wr(3'h6, 8'(rnd()), 8'(rnd()));
    `CHK("port out", m_out, port_out)
    `CHK("port oe", m_cfg, port_oe_n)
    rd(3'h7);
    rd(3'h3);
    rd(3'h1);
    $display("test write_pairs done");
    wr(3'h6, 8'hff, 8'h00);
    rd(3'h0);
    chk_alert();
    set_ext(ext ^ 16'h0001);
    chk_alert();
    set_ext(ext ^ 16'h0100);
    chk_alert();
    set_ext(ext ^ 16'h0001);
    chk_alert();
    set_ext(ext ^ 16'h0008);
    chk_alert();
    rd(3'h0);
    chk_alert();
    set_ext(ext ^ 16'h0008);
    chk_alert();
    $display("test alert done");
    foreign();
    chk_alert();
    @(posedge sys_clk);
    addr_sel <= 1'b1;
    cyc(10);
    rd(3'h0);
    chk_alert();
    set_ext(ext ^ 16'h0080);
    foreign();
    chk_alert();
    repeat (2) begin
      set_ext(16'(rnd()));
      rd(3'h0);
      chk_alert();
    end
    $display("test address_select done");
    wr(3'h2, 8'(rnd()), 8'(rnd()));
    wr(3'h6, 8'h00, 8'h00);
    pulse_reset(1'b0);
    rd(3'h6);
    wr(3'h2, 8'h5a, 8'ha5);
    pulse_reset(1'b1);
    rd(3'h2);
    $display("test mid_run_reset done");
    close_out();
  end
endmodule
